// ==== core/flash_host_pkg.sv ====
// package: command codes, status bits, pin timing and register map of the flash host controller
package flash_host_pkg;
  // command bytes written to the device
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_IDENTIFY     = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [15:0] NULL_WORD       = 16'hFFFF;
  localparam logic [15:0] NULL_BYTE       = 16'h00FF;
  // identify addresses
  localparam logic [17:0] ID_MAKER_ADDR   = 18'h00000;
  localparam logic [17:0] ID_PART_ADDR    = 18'h00001;
  // status byte bit positions
  localparam int READY_BIT   = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int ERASE_BIT   = 5;
  localparam int PROGRAM_BIT = 4;
  localparam int SUPPLY_BIT  = 3;
  // block select field: word parts A12-A16, byte parts A13-A17
  localparam int BLK_LSB_WORD = 12;
  localparam int BLK_LSB_BYTE = 13;
  localparam int BLK_W        = 5;
  // pin timing in ns and derived cycle counts at 25 MHz
  localparam int CLK_NS          = 40;
  localparam int STROBE_NS       = 80;
  localparam int RESET_NS        = 200;
  localparam int STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC       = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] RESET_CNT  = 4'(RESET_CYC);
  // apb register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // operation codes in ctrl[3:0]; writing ctrl starts it
  localparam logic [3:0] OP_READ     = 4'h0;
  localparam logic [3:0] OP_IDENT    = 4'h1;
  localparam logic [3:0] OP_STATUS   = 4'h2;
  localparam logic [3:0] OP_CLEAR    = 4'h3;
  localparam logic [3:0] OP_PROGRAM  = 4'h4;
  localparam logic [3:0] OP_ERASE    = 4'h5;
  localparam logic [3:0] OP_SUSPEND  = 4'h6;
  localparam logic [3:0] OP_RESUME   = 4'h7;
  localparam logic [3:0] OP_NULLPROG = 4'h8;
  localparam logic [3:0] OP_RESET    = 4'h9;
  localparam logic [3:0] OP_ARRAY    = 4'hA;
  // ctrl bit fields
  localparam int CTRL_WORD_BIT = 4;
  localparam int CTRL_BOOT_BIT = 5;
  localparam int CTRL_ALT_BIT  = 6;
endpackage

// ==== core/flash_bus_cycle.sv ====
// one device bus cycle: write or read strobe held for a fixed count of clocks
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter logic [3:0] HOLD = flash_host_pkg::STROBE_CNT
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request from sequencer
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // device pins
  output logic [17:0]      dev_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n
);
  import flash_host_pkg::*;
  logic [3:0] count;
  logic       busy;
  wire        last = busy && (count == 4'h1);

  // address latched at cycle start and not moved until the strobe ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      count    <= 4'h0;
      dev_addr <= 18'h00000;
      dq_out   <= 16'h0000;
      dq_oe    <= 1'b0;
      ce_n     <= 1'b1;
      we_n     <= 1'b1;
      oe_n     <= 1'b1;
      rdata    <= 16'h0000;
      done     <= 1'b0;
    end else begin
      done <= last;
      if (start && !busy) begin
        busy     <= 1'b1;
        count    <= HOLD;
        dev_addr <= addr;
        dq_out   <= wdata;
        dq_oe    <= is_write;
        ce_n     <= 1'b0;
        we_n     <= !is_write;
        oe_n     <= is_write;
      end else if (last) begin
        // read data sampled before the strobe rises
        if (!oe_n) rdata <= dq_in;
        busy  <= 1'b0;
        count <= 4'h0;
        ce_n  <= 1'b1;
        we_n  <= 1'b1;
        oe_n  <= 1'b1;
        dq_oe <= 1'b0;
      end else if (busy) begin
        count <= count - 4'h1;
      end
    end
  end

  AST_ADDR_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && $past(busy)) |-> $stable(dev_addr))
    else $error("address moved during a bus cycle");
  // the data bus is driven only under the write strobe, never under the read strobe
  AST_DRIVE_ON_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (!we_n || !oe_n) |-> (dq_oe == !we_n))
    else $error("data bus drive does not follow the strobe");
endmodule
`default_nettype wire

// ==== core/flash_host_ctrl.sv ====
// host controller: apb registers and command sequencing toward the boot-block flash
// Operation
// - After program or erase, write FFH once to return to array reads.
// - Host holds the address stable for the whole write cycle.
// - A lone program setup is cancelled by writing all ones.
// - Host keeps strobes inactive or reset low while supply ramps.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic [17:0]      dev_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic             reset_powerdown_n,
  output logic             unlock_high_voltage,
  output logic             boot_unlock,
  output logic             word_mode
);
  import flash_host_pkg::*;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_RESET = 7'b0000010,
    S_CMD   = 7'b0000100,
    S_DATA  = 7'b0001000,
    S_POLL  = 7'b0010000,
    S_READ  = 7'b0100000,
    S_DONE  = 7'b1000000
  } state_t;

  state_t      state;
  state_t      next_state;
  logic [3:0]  op;
  logic [17:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0]  status_byte;
  logic        word_sel;
  logic        boot_sel;
  logic        alt_sel;
  logic        refused;
  logic        erasing;
  logic [3:0]  rst_cnt;
  logic        cyc_start;
  logic        cyc_write;
  logic [17:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic        cyc_done;
  logic [15:0] cyc_rdata;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_wr     = psel && penable && pwrite;
  wire busy       = (state != S_IDLE);
  wire hit_ctrl   = (paddr == REG_CTRL);
  wire hit_addr   = (paddr == REG_ADDR);
  wire hit_wdata  = (paddr == REG_WDATA);
  wire hit_rdata  = (paddr == REG_RDATA);
  wire hit_status = (paddr == REG_STATUS);
  wire mapped     = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_status;
  wire go         = apb_wr && hit_ctrl && !busy;
  wire [31:0] ctrl_rd   = {25'h0, alt_sel, boot_sel, word_sel, 2'b00, busy, refused};
  wire [31:0] status_rd = {16'h0, 8'h00, status_byte};
  wire [4:0]  block_idx = word_sel ? addr_reg[BLK_LSB_WORD +: BLK_W]
                                   : addr_reg[BLK_LSB_BYTE +: BLK_W];

  // single wait-free access; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = hit_ctrl   ? ctrl_rd :
                   hit_addr   ? {14'h0, addr_reg} :
                   hit_wdata  ? {16'h0, wdata_reg} :
                   hit_rdata  ? {16'h0, rdata_reg} :
                   hit_status ? status_rd : 32'h0000_0000;

  // word_mode and boot_unlock steered by ctrl bits; unlock_high_voltage tied low
  assign word_mode           = word_sel;
  assign boot_unlock         = boot_sel;
  assign unlock_high_voltage = 1'b0;

  // ----------------------------------------------------------------
  // first command byte for each operation
  // ----------------------------------------------------------------
  logic [7:0] first_cmd;
  always_comb begin
    unique case (op)
      OP_READ, OP_ARRAY: first_cmd = CMD_READ_ARRAY;
      OP_IDENT:          first_cmd = CMD_IDENTIFY;
      OP_STATUS:         first_cmd = CMD_READ_STATUS;
      OP_CLEAR:          first_cmd = CMD_CLEAR_STATUS;
      OP_PROGRAM,
      OP_NULLPROG:       first_cmd = alt_sel ? CMD_PROG_ALT : CMD_PROG_SETUP;
      OP_ERASE:          first_cmd = CMD_ERASE_SETUP;
      OP_SUSPEND:        first_cmd = CMD_SUSPEND;
      OP_RESUME:         first_cmd = CMD_CONFIRM;
      default:           first_cmd = CMD_READ_ARRAY;
    endcase
  end

  wire two_cycle = (op == OP_PROGRAM) || (op == OP_ERASE) || (op == OP_NULLPROG);
  wire polls     = (op == OP_PROGRAM) || (op == OP_ERASE) || (op == OP_SUSPEND);
  wire reads     = (op == OP_READ) || (op == OP_IDENT) || (op == OP_STATUS);
  // supply error blocks new changes in the device; host refuses up front too
  wire blocked_w = (pwdata[3:0] == OP_PROGRAM || pwdata[3:0] == OP_ERASE)
                   && status_byte[SUPPLY_BIT];
  wire ready_now = cyc_rdata[READY_BIT];
  wire [15:0] null_val = word_sel ? NULL_WORD : NULL_BYTE;

  // ----------------------------------------------------------------
  // bus cycle request
  // ----------------------------------------------------------------
  assign cyc_start = (state == S_CMD) || (state == S_DATA) ||
                     (state == S_POLL) || (state == S_READ);
  assign cyc_write = (state == S_CMD) || (state == S_DATA);
  assign cyc_addr  = (state == S_READ || state == S_DATA) ? addr_reg : 18'h00000;
  assign cyc_wdata = (state == S_CMD) ? {8'h00, first_cmd} :
                     (op == OP_ERASE) ? {8'h00, CMD_CONFIRM} :
                     (op == OP_NULLPROG) ? null_val : wdata_reg;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:  if (go) next_state = S_CMD;
      S_RESET: if (rst_cnt == 4'h0) next_state = S_DONE;
      S_CMD:   if (cyc_done) next_state = two_cycle ? S_DATA
                                        : polls ? S_POLL
                                        : reads ? S_READ : S_DONE;
      S_DATA:  if (cyc_done) next_state = (op == OP_NULLPROG) ? S_DONE : S_POLL;
      // a busy device returns status on every read until ready
      S_POLL:  if (cyc_done && ready_now) next_state = S_DONE;
      S_READ:  if (cyc_done) next_state = S_DONE;
      S_DONE:  next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state and register file
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
    end else if (go && blocked_w) begin
      state <= S_IDLE;
    end else if (go && (pwdata[3:0] == OP_RESET)) begin
      state <= S_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op       <= OP_READ;
      word_sel <= 1'b0;
      boot_sel <= 1'b0;
      alt_sel  <= 1'b0;
      refused  <= 1'b0;
    end else if (go) begin
      op       <= pwdata[3:0];
      word_sel <= pwdata[CTRL_WORD_BIT];
      boot_sel <= pwdata[CTRL_BOOT_BIT];
      alt_sel  <= pwdata[CTRL_ALT_BIT];
      refused  <= blocked_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= 18'h00000;
      wdata_reg <= 16'h0000;
    end else if (apb_wr && !busy) begin
      if (hit_addr)  addr_reg  <= pwdata[17:0];
      if (hit_wdata) wdata_reg <= pwdata[15:0];
    end
  end

  // reset pin pulse, strobes idle while it is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt           <= 4'h0;
      reset_powerdown_n <= 1'b0;
    end else if (go && (pwdata[3:0] == OP_RESET)) begin
      rst_cnt           <= RESET_CNT;
      reset_powerdown_n <= 1'b0;
    end else if (rst_cnt != 4'h0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end else begin
      reset_powerdown_n <= 1'b1;
    end
  end

  // data capture; the status mirror holds the last polled or status-read byte, cleared by reset, error flags masked by clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg   <= 16'h0000;
      status_byte <= 8'h00;
      erasing     <= 1'b0;
    end else if (state == S_RESET) begin
      status_byte <= 8'h00;
      erasing     <= 1'b0;
    end else if (cyc_done && state == S_POLL) begin
      status_byte <= cyc_rdata[7:0];
      erasing     <= (op == OP_ERASE) && !ready_now;
    end else if (cyc_done && state == S_READ) begin
      rdata_reg <= cyc_rdata;
      if (op == OP_STATUS) status_byte <= cyc_rdata[7:0];
    end else if (state == S_DONE && op == OP_CLEAR) begin
      status_byte <= status_byte & 8'hC7;
    end
  end

  // ----------------------------------------------------------------
  // device bus cycle engine
  // ----------------------------------------------------------------
  flash_bus_cycle #(.HOLD(STROBE_CNT)) u_cycle (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (cyc_start && !cyc_done),
    .is_write (cyc_write),
    .addr     (cyc_addr),
    .wdata    (cyc_wdata),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .dev_addr (dev_addr),
    .dq_out   (dq_out),
    .dq_oe    (dq_oe),
    .dq_in    (dq_in),
    .ce_n     (ce_n),
    .we_n     (we_n),
    .oe_n     (oe_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    (go && blocked_w) |=> (state == S_IDLE && refused))
    else $error("change operation not refused under supply error");
  AST_STROBE_IN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_powerdown_n |-> (we_n && ce_n))
    else $error("strobe active while reset pin low");
  AST_POLL_UNTIL_READY: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_POLL && cyc_done && !ready_now) |=> state == S_POLL)
    else $error("polling ended while device busy");
  AST_CONFIRM_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_DATA && op == OP_ERASE && !we_n) |-> dq_out[7:0] == CMD_CONFIRM)
    else $error("erase second cycle not confirm");
  AST_NULL_ALL_ONES: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_DATA && op == OP_NULLPROG && !we_n) |-> dq_out == null_val)
    else $error("null program not all ones");
  AST_FIRST_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_CMD && !we_n && op == OP_SUSPEND) |-> dq_out[7:0] == CMD_SUSPEND)
    else $error("suspend code wrong");
  AST_RESET_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_RESET) |=> status_byte == 8'h00)
    else $error("status not cleared by reset");
  AST_CLEAR_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_DONE && op == OP_CLEAR) |=> status_byte[5:3] == 3'b000)
    else $error("clear status left error flags");
  // while the device erases, the host only polls, so no other command can reach it
  AST_ERASE_ONLY_POLL: assert property (@(posedge pclk) disable iff (!presetn)
    erasing |-> (state == S_POLL))
    else $error("command issued while erase in progress");
  AST_ERASE_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_DATA && op == OP_ERASE && !we_n) |->
      (block_idx == (word_sel ? dev_addr[BLK_LSB_WORD +: BLK_W]
                              : dev_addr[BLK_LSB_BYTE +: BLK_W])))
    else $error("erase confirm outside the chosen block");
endmodule
`default_nettype wire

// ==== verif/flash_dev_model.sv ====
// behavioural boot-block flash device that answers the host controller pins
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00C3,  // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h003C,  // arbitrary value
  parameter int          BUSY_READS = 3,
  parameter logic [4:0]  BOOT_BLK   = 5'h00
) (
  // device pins
  input  wire logic [17:0] dev_addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        unlock_high_voltage,
  input  wire logic        boot_unlock,
  input  wire logic        word_mode,
  // program supply level set by the bench
  input  wire logic        vpp_ok,
  output logic [15:0]      dq_in
);
  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  logic [15:0] mem [0:(1<<18)-1];  // whole array, all ones until written
  logic        cmd_sel = 1'b0;  // chip select seen while the write strobe was low
  logic [15:0] rd_val = 16'h0000;
  logic [17:0] wa;
  logic [15:0] wd;
  logic [1:0]  mode = 2'd0;  // 0 array, 1 identify, 2 status
  logic [1:0]  pend = 2'd0;  // 0 none, 1 program, 2 erase
  logic        erasing = 1'b0;
  logic        susp = 1'b0;
  logic [2:0]  err = 3'b000;  // erase, program, supply
  int          busy = 0;
  int          busy_save = 0;
  wire  logic [7:0] status_byte = {busy == 0, susp, err, 3'b000};

  // blank array at start
  initial foreach (mem[i]) mem[i] = 16'hFFFF;

  function automatic logic [4:0] blk(input logic [17:0] a);
    return word_mode ? a[16:12] : a[17:13];
  endfunction

  // second cycle of a program or erase sequence
  task automatic commit_op();
    mode = 2'd2;
    if (pend == 2'd1 && wd == (word_mode ? NULL_WORD : NULL_BYTE)) mode = 2'd0;
    else if (pend == 2'd2 && wd[7:0] != CMD_CONFIRM) err[2:1] = 2'b11;
    else if (err[0] || !vpp_ok) err[0] = 1'b1;
    else if (blk(wa) == BOOT_BLK && !boot_unlock && !unlock_high_voltage)
      err[pend == 2'd1 ? 1 : 2] = 1'b1;
    else if (pend == 2'd1) begin
      mem[wa] = wd;
      busy = BUSY_READS;
    end else begin
      foreach (mem[i]) if (blk(18'(i)) == blk(wa)) mem[i] = 16'hFFFF;
      erasing = 1'b1;
      busy = BUSY_READS;
    end
    pend = 2'd0;
  endtask

  // latch address and data once the strobe has settled, so launch races do not matter
  always @(negedge we_n) begin
    #1;
    wa = dev_addr;
    wd = dq_out;
    // chip select rises in the same step as the strobe, so take it here
    cmd_sel = !ce_n;
  end

  // a command takes effect as the write strobe rises
  always @(posedge we_n) begin
    if (cmd_sel && reset_powerdown_n) begin
      if (busy != 0) begin
        if (wd[7:0] == CMD_SUSPEND && erasing) begin
          susp = 1'b1;
          busy_save = busy;
          busy = 0;
        end
      end else if (susp) begin
        if (wd[7:0] == CMD_CONFIRM) begin
          susp = 1'b0;
          busy = busy_save;
          mode = 2'd2;
        end else if (wd[7:0] == CMD_READ_ARRAY) mode = 2'd0;
        else if (wd[7:0] == CMD_READ_STATUS) mode = 2'd2;
      end else if (pend != 2'd0) begin
        commit_op();
      end else begin
        case (wd[7:0])
          CMD_READ_ARRAY:               mode = 2'd0;
          CMD_IDENTIFY:                 mode = 2'd1;
          CMD_READ_STATUS:              mode = 2'd2;
          CMD_CLEAR_STATUS:             err = 3'b000;
          CMD_ERASE_SETUP:              pend = 2'd2;
          CMD_PROG_SETUP, CMD_PROG_ALT: pend = 2'd1;
          default: ;
        endcase
      end
    end
  end

  // each read lets the sequencer advance; chip select is not needed for it
  always @(posedge oe_n) begin
    if (busy > 0) busy = busy - 1;
    if (busy == 0 && !susp) erasing = 1'b0;
  end

  // read data is chosen after the output strobe falls
  always @(negedge oe_n) begin
    #1;
    if (busy != 0 || mode == 2'd2) rd_val = {8'h00, status_byte};
    else if (mode == 2'd1) rd_val = dev_addr[0] ? PART_CODE : MAKER_CODE;
    else rd_val = mem[dev_addr];
  end

  // a released bus shows the inverse of the last word so stale data never passes
  assign dq_in = (!ce_n && !oe_n) ? rd_val : ~rd_val;

  // reset pin low returns everything to array read with a clear status
  always @(negedge reset_powerdown_n) begin
    mode = 2'd0;
    pend = 2'd0;
    err = 3'b000;
    susp = 1'b0;
    busy = 0;
    erasing = 1'b0;
  end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench: apb tasks drive the host controller against the device model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  import flash_host_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [15:0] MAKER = 16'h00C3;  // arbitrary value
  localparam logic [15:0] PART  = 16'h003C;  // arbitrary value
  localparam logic [2:0]  W = 3'b001, ALT = 3'b101, BOOT = 3'b011, BYTE = 3'b000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err_seen, vpp_ok = 1'b1;
  logic [17:0] dev_addr;
  logic [15:0] dq_out, dq_in;
  logic        dq_oe, ce_n, we_n, oe_n, reset_powerdown_n;
  logic        unlock_high_voltage, boot_unlock, word_mode;
  int          mismatches = 0;
  int          total_checks = 0;

  always #20 pclk = ~pclk;

  flash_host_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dev_addr, .dq_out, .dq_oe, .dq_in, .ce_n, .we_n, .oe_n,
    .reset_powerdown_n, .unlock_high_voltage, .boot_unlock, .word_mode);
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev (.dev_addr, .dq_out, .ce_n,
    .we_n, .oe_n, .reset_powerdown_n, .unlock_high_voltage, .boot_unlock, .word_mode,
    .vpp_ok, .dq_in);

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // idle edge at the end keeps back-to-back calls from assigning psel twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err_seen = pslverr;
    if (n == 20) begin mismatches++; stop_test(); end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask

  // load address and data, start the op, poll busy; rd ends holding ctrl
  task automatic run_op(input logic [17:0] a, input logic [15:0] d, input logic [3:0] op,
                        input logic [2:0] fl);
    int n;
    n = 0;
    apb(1'b1, REG_ADDR, {14'h0, a});
    apb(1'b1, REG_WDATA, {16'h0, d});
    apb(1'b1, REG_CTRL, {25'h0, fl, op});
    rd = 32'h0000_0002;
    while (rd[1] !== 1'b0 && n < 400) begin
      apb(1'b0, REG_CTRL, 32'h0000_0000);
      n++;
    end
    if (n == 400) begin mismatches++; stop_test(); end
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("status after reset", REG_STATUS, 32'h0000_0000);
    `CHK("reset pin released", 1'b1, reset_powerdown_n)
    run_op(18'h00000, 16'h0000, OP_IDENT, W);
    rd_chk("maker code", REG_RDATA, {16'h0, MAKER});
    run_op(18'h00001, 16'h0000, OP_IDENT, W);
    rd_chk("part code", REG_RDATA, {16'h0, PART});
    run_op(18'h01234, 16'h1234, OP_PROGRAM, W);
    rd_chk("ready after program", REG_STATUS, 32'h0000_0080);
    run_op(18'h01234, 16'h0000, OP_READ, W);
    rd_chk("programmed word", REG_RDATA, 32'h0000_1234);
    run_op(18'h01236, 16'h5678, OP_PROGRAM, ALT);
    run_op(18'h01236, 16'h0000, OP_READ, W);
    rd_chk("alternate setup word", REG_RDATA, 32'h0000_5678);
    run_op(18'h01238, 16'h0000, OP_NULLPROG, W);
    run_op(18'h01238, 16'h0000, OP_READ, W);
    rd_chk("null write", REG_RDATA, 32'h0000_FFFF);
    run_op(18'h00010, 16'h0A0A, OP_PROGRAM, W);
    rd_chk("locked boot block", REG_STATUS, 32'h0000_0090);
    run_op(18'h00000, 16'h0000, OP_STATUS, W);
    rd_chk("status read op", REG_STATUS, 32'h0000_0090);
    run_op(18'h00000, 16'h0000, OP_CLEAR, W);
    run_op(18'h00000, 16'h0000, OP_STATUS, W);
    rd_chk("flags cleared", REG_STATUS, 32'h0000_0080);
    run_op(18'h00010, 16'h0A0A, OP_PROGRAM, BOOT);
    run_op(18'h00010, 16'h0000, OP_READ, W);
    rd_chk("unlocked boot word", REG_RDATA, 32'h0000_0A0A);
    run_op(18'h01000, 16'h0000, OP_ERASE, W);
    rd_chk("erase done", REG_STATUS, 32'h0000_0080);
    run_op(18'h01234, 16'h0000, OP_READ, W);
    rd_chk("erased word", REG_RDATA, 32'h0000_FFFF);
    run_op(18'h00010, 16'h0000, OP_READ, W);
    rd_chk("other block kept", REG_RDATA, 32'h0000_0A0A);
    run_op(18'h03000, 16'h0055, OP_PROGRAM, BYTE);
    run_op(18'h02000, 16'h0000, OP_ERASE, BYTE);
    run_op(18'h03000, 16'h0000, OP_READ, BYTE);
    rd_chk("byte part block erase", REG_RDATA, 32'h0000_FFFF);
    vpp_ok <= 1'b0;
    run_op(18'h01240, 16'h1111, OP_PROGRAM, W);
    rd_chk("supply missing", REG_STATUS, 32'h0000_0088);
    run_op(18'h01240, 16'h1111, OP_PROGRAM, W);
    `CHK("program refused", 1'b1, rd[0])
    `CHK("word flag readback", 1'b1, rd[CTRL_WORD_BIT])
    vpp_ok <= 1'b1;
    run_op(18'h00000, 16'h0000, OP_ARRAY, W);
    run_op(18'h00000, 16'h0000, OP_SUSPEND, W);
    rd_chk("idle suspend polls array", REG_STATUS, 32'h0000_00FF);
    run_op(18'h00000, 16'h0000, OP_RESUME, W);
    run_op(18'h00000, 16'h0000, OP_RESET, W);
    run_op(18'h00000, 16'h0000, OP_STATUS, W);
    rd_chk("status after reset pulse", REG_STATUS, 32'h0000_0080);
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped slave error", 1'b1, err_seen)
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
